//--- logic/acp_mode_port.sv
`timescale 1ns/100ps
module acp_mode_port
(
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                program_mode_select,
    input  wire logic                cs_n,
    input  wire logic                sck,
    input  wire logic                sdi,
    input  wire logic                sdo_in,
    output logic                     sdo_out,
    output logic                     sdo_oe,
    input  wire logic                sample_valid,
    input  wire acp_pkg::acp_sample_s sample_in,
    output acp_pkg::acp_sample_s     sample_out,
    output logic                     sample_oe,
    output logic                     sample_clock_out,
    output logic                     sample_clock_oe,
    output logic [1:0]               power_down_code,
    output logic [1:0]               output_mode,
    output logic                     duty_cycle_stabilizer_en,
    output logic [1:0]               out_clock_phase_sel,
    output logic                     out_clock_invert
);

    // pins are asynchronous: two flops before any use
    logic [4:0]           sync1_r;
    logic [4:0]           sync2_r;
    logic                 sck_prev_r, cs_prev_r;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sync1_r    <= 5'h09; // idle levels: serial mode, cs high, sck low, sdo pulled up
            sync2_r    <= 5'h09;
            sck_prev_r <= 1'b0;
            cs_prev_r  <= 1'b1;
        end
        else
        begin
            sync1_r    <= {program_mode_select, cs_n, sck, sdi, sdo_in};
            sync2_r    <= sync1_r;
            sck_prev_r <= sync2_r[2];
            cs_prev_r  <= sync2_r[3];
        end
    end

    logic par_mode, cs_s, sck_s, sdi_s, sdo_s;
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    assign par_mode = sync2_r[4];
    assign cs_s     = sync2_r[3];
    assign sck_s    = sync2_r[2];
    assign sdi_s    = sync2_r[1];
    assign sdo_s    = sync2_r[0];
    assign sck_rise = sck_s & ~sck_prev_r;
    assign sck_fall = ~sck_s & sck_prev_r;
    assign cs_fall  = ~cs_s & cs_prev_r;
    assign cs_rise  = cs_s & ~cs_prev_r;

    // serial port and register file
    acp_pkg::acp_state_e st_r, st_nxt;
    logic [4:0]           cnt_r, cnt_nxt;
    logic [15:0]          sr_r, sr_nxt;
    logic [7:0]           rd_r, rd_nxt;
    logic                 rding_r, rding_nxt, off_r, off_nxt, sdo_oe_r, sdo_oe_nxt;
    logic [7:0]           srst_r, srst_nxt;
    logic [1:0]           pd_r, pd_nxt;
    logic [3:0]           tim_r, tim_nxt;
    logic [5:0]           fmt_r, fmt_nxt;
    acp_pkg::acp_word_s   word;

    function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] srst, input logic [1:0] pd,
                                            input logic [3:0] tim, input logic off, input logic [5:0] fmt);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            acp_pkg::ADDR_SOFT_RESET_CTRL:     v[acp_pkg::SOFT_RESET_BIT] = (srst != 8'h00);
            acp_pkg::ADDR_POWER_DOWN_CTRL:     v[1:0] = pd;
            acp_pkg::ADDR_OUTPUT_CLOCK_TIMING: v[3:0] = tim;
            acp_pkg::ADDR_OUTPUT_MODE:         v[acp_pkg::TRISTATE_BIT] = off;
            acp_pkg::ADDR_DATA_FORMAT:         v[5:0] = fmt;
            default:                           v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb
    begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        sr_nxt    = sr_r;
        rd_nxt    = rd_r;
        rding_nxt = rding_r;
        srst_nxt  = srst_r;
        pd_nxt    = pd_r;
        tim_nxt   = tim_r;
        off_nxt   = off_r;
        fmt_nxt   = fmt_r;
        word      = acp_pkg::acp_word_s'({sr_r[14:0], sdi_s});
        if (srst_r != 8'h00)
            srst_nxt = srst_r - 8'h01;
        if (par_mode)
        begin
            st_nxt    = acp_pkg::ST_IDLE;
            rding_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                acp_pkg::ST_IDLE:
                begin
                    if (cs_fall)
                    begin
                        st_nxt    = acp_pkg::ST_SHIFT;
                        cnt_nxt   = 5'h00;
                        rding_nxt = 1'b0;
                    end
                end
                acp_pkg::ST_SHIFT:
                begin
                    if (cs_rise)
                    begin
                        st_nxt    = acp_pkg::ST_IDLE;
                        rding_nxt = 1'b0;
                    end
                    else if (sck_rise)
                    begin
                        sr_nxt  = {sr_r[14:0], sdi_s};
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_nxt == acp_pkg::HEADER_BITS && sr_r[6])
                        begin
                            rding_nxt = 1'b1;
                            rd_nxt    = reg_read({sr_r[5:0], sdi_s}, srst_r, pd_r, tim_r, off_r, fmt_r);
                        end
                        if (cnt_nxt == acp_pkg::WORD_BITS)
                        begin
                            st_nxt = acp_pkg::ST_HOLD;
                            if (!rding_r)
                            begin
                                unique case (word.addr)
                                    acp_pkg::ADDR_SOFT_RESET_CTRL:
                                    begin
                                        if (word.data[acp_pkg::SOFT_RESET_BIT])
                                        begin
                                            srst_nxt = acp_pkg::SOFT_RESET_CYCLES;
                                            pd_nxt   = acp_pkg::POWER_DOWN_RESET;
                                            tim_nxt  = acp_pkg::TIMING_RESET;
                                            off_nxt  = acp_pkg::TRISTATE_RESET;
                                            fmt_nxt  = acp_pkg::FORMAT_RESET;
                                        end
                                    end
                                    acp_pkg::ADDR_POWER_DOWN_CTRL:     pd_nxt  = word.data[1:0];
                                    acp_pkg::ADDR_OUTPUT_CLOCK_TIMING: tim_nxt = word.data[3:0];
                                    acp_pkg::ADDR_OUTPUT_MODE:         off_nxt = word.data[acp_pkg::TRISTATE_BIT];
                                    acp_pkg::ADDR_DATA_FORMAT:         fmt_nxt = word.data[5:0];
                                    default:                           ;
                                endcase
                            end
                        end
                    end
                    else if (sck_fall && rding_r && cnt_r > acp_pkg::HEADER_BITS)
                        rd_nxt = {rd_r[6:0], 1'b1};
                end
                acp_pkg::ST_HOLD:
                begin
                    // clocks past the sixteenth are ignored
                    if (cs_rise)
                    begin
                        st_nxt    = acp_pkg::ST_IDLE;
                        rding_nxt = 1'b0;
                    end
                    else if (sck_fall && rding_r)
                        rd_nxt = {rd_r[6:0], 1'b1};
                end
                default: st_nxt = acp_pkg::ST_IDLE;
            endcase
        end
        // drive low only for a zero bit; a one is left to the pull-up
        sdo_oe_nxt = rding_nxt && !rd_nxt[7] && (st_nxt != acp_pkg::ST_IDLE) && (cnt_nxt >= acp_pkg::HEADER_BITS);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_r     <= acp_pkg::ST_IDLE;
            cnt_r    <= 5'h00;
            sr_r     <= 16'h0000;
            rd_r     <= 8'hFF;
            rding_r  <= 1'b0;
            srst_r   <= 8'h00;
            pd_r     <= acp_pkg::POWER_DOWN_RESET;
            tim_r    <= acp_pkg::TIMING_RESET;
            off_r    <= acp_pkg::TRISTATE_RESET;
            fmt_r    <= acp_pkg::FORMAT_RESET;
            sdo_oe_r <= 1'b0;
        end
        else
        begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            sr_r     <= sr_nxt;
            rd_r     <= rd_nxt;
            rding_r  <= rding_nxt;
            srst_r   <= srst_nxt;
            pd_r     <= pd_nxt;
            tim_r    <= tim_nxt;
            off_r    <= off_nxt;
            fmt_r    <= fmt_nxt;
            sdo_oe_r <= sdo_oe_nxt;
        end
    end

    assign sdo_out = 1'b0;
    assign sdo_oe  = sdo_oe_r;
    // mode outputs and sample path
    logic [1:0]           pdc_r, pdc_nxt, om_r, om_nxt, ph_r, ph_nxt;
    logic                 dcs_r, dcs_nxt, inv_r, inv_nxt, oe_r, oe_nxt, alt_r, alt_nxt, sclk_r, sclk_nxt;
    acp_pkg::acp_sample_s so_r, so_nxt;
    logic [2:0]           test;
    logic [15:0]          d;

    always_comb
    begin
        alt_nxt = alt_r;
        so_nxt  = so_r;
        d       = sample_in.data;
        test    = fmt_r[acp_pkg::TEST_LSB +: 3];
        if (par_mode)
        begin
            dcs_nxt  = cs_s;
            om_nxt   = sck_s ? acp_pkg::OUT_MODE_LVDS : acp_pkg::OUT_MODE_CMOS;
            pdc_nxt  = {sdi_s, sdo_s};
            ph_nxt   = 2'h0;
            inv_nxt  = 1'b0;
            oe_nxt   = 1'b1;
            test     = acp_pkg::TEST_OFF;
        end
        else
        begin
            dcs_nxt  = tim_r[acp_pkg::DCS_BIT];
            om_nxt   = acp_pkg::OUT_MODE_CMOS;
            pdc_nxt  = (srst_r != 8'h00) ? acp_pkg::PD_SLEEP : pd_r;
            ph_nxt   = tim_r[acp_pkg::PHASE_LSB +: 2];
            inv_nxt  = tim_r[acp_pkg::CLOCK_INVERT_BIT];
            oe_nxt   = ~off_r;
        end
        // sample clock follows valid; phase delay is applied in the output pad
        sclk_nxt = sample_valid ^ inv_nxt;
        if (sample_valid)
        begin
            alt_nxt = ~alt_r;
            // alternate polarity forces offset binary
            if (fmt_r[acp_pkg::TWOS_BIT] && !fmt_r[acp_pkg::ABP_BIT])
                d[15] = ~d[15];
            if (fmt_r[acp_pkg::RAND_BIT])
                d[15:1] = d[15:1] ^ {15{d[0]}};
            if (fmt_r[acp_pkg::ABP_BIT])
                d = d ^ acp_pkg::ODD_BITS;
            unique case (test)
                acp_pkg::TEST_ZEROS:   so_nxt = 17'h00000;
                acp_pkg::TEST_ONES:    so_nxt = 17'h1FFFF;
                acp_pkg::TEST_CHECKER: so_nxt = alt_r ? acp_pkg::CHECKER_B : acp_pkg::CHECKER_A;
                acp_pkg::TEST_TOGGLE:  so_nxt = alt_r ? 17'h1FFFF : 17'h00000;
                default:               so_nxt = {sample_in.overrange, d};
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pdc_r  <= acp_pkg::PD_NORMAL;
            om_r   <= acp_pkg::OUT_MODE_CMOS;
            dcs_r  <= 1'b0;
            ph_r   <= 2'h0;
            inv_r  <= 1'b0;
            oe_r   <= 1'b1;
            alt_r  <= 1'b0;
            sclk_r <= 1'b0;
            so_r   <= 17'h00000;
        end
        else
        begin
            pdc_r  <= pdc_nxt;
            om_r   <= om_nxt;
            dcs_r  <= dcs_nxt;
            ph_r   <= ph_nxt;
            inv_r  <= inv_nxt;
            oe_r   <= oe_nxt;
            alt_r  <= alt_nxt;
            sclk_r <= sclk_nxt;
            so_r   <= so_nxt;
        end
    end

    assign sample_out               = so_r;
    assign sample_oe                = oe_r;
    assign sample_clock_out         = sclk_r;
    assign sample_clock_oe          = oe_r;
    assign power_down_code          = pdc_r;
    assign output_mode              = om_r;
    assign duty_cycle_stabilizer_en = dcs_r;
    assign out_clock_phase_sel      = ph_r;
    assign out_clock_invert         = inv_r;

endmodule

//--- logic/acp_pkg.sv
package acp_pkg;

    // register offsets
    localparam logic [6:0] ADDR_SOFT_RESET_CTRL     = 7'h00;
    localparam logic [6:0] ADDR_POWER_DOWN_CTRL     = 7'h01;
    localparam logic [6:0] ADDR_OUTPUT_CLOCK_TIMING = 7'h02;
    localparam logic [6:0] ADDR_OUTPUT_MODE         = 7'h03;
    localparam logic [6:0] ADDR_DATA_FORMAT         = 7'h04;

    // field positions
    localparam int SOFT_RESET_BIT   = 7;
    localparam int CLOCK_INVERT_BIT = 3;
    localparam int PHASE_LSB        = 1;
    localparam int DCS_BIT          = 0;
    localparam int TRISTATE_BIT     = 2;
    localparam int TEST_LSB         = 3;
    localparam int ABP_BIT          = 2;
    localparam int RAND_BIT         = 1;
    localparam int TWOS_BIT         = 0;

    // reset values
    localparam logic [1:0] POWER_DOWN_RESET = 2'h0;
    localparam logic [3:0] TIMING_RESET     = 4'h0;
    localparam logic       TRISTATE_RESET   = 1'b0;
    localparam logic [5:0] FORMAT_RESET     = 6'h00;

    // power-down codes
    localparam logic [1:0] PD_NORMAL   = 2'h0;
    localparam logic [1:0] PD_CH2_NAP  = 2'h1;
    localparam logic [1:0] PD_BOTH_NAP = 2'h2;
    localparam logic [1:0] PD_SLEEP    = 2'h3;

    // output modes
    localparam logic [1:0] OUT_MODE_CMOS = 2'h0;
    localparam logic [1:0] OUT_MODE_LVDS = 2'h1;

    // test patterns
    localparam logic [2:0] TEST_OFF     = 3'h0;
    localparam logic [2:0] TEST_ZEROS   = 3'h1;
    localparam logic [2:0] TEST_ONES    = 3'h3;
    localparam logic [2:0] TEST_CHECKER = 3'h5;
    localparam logic [2:0] TEST_TOGGLE  = 3'h7;

    localparam logic [16:0] CHECKER_A = 17'h15555;
    localparam logic [16:0] CHECKER_B = 17'h0AAAA;
    localparam logic [15:0] ODD_BITS  = 16'hAAAA;

    // serial word
    localparam logic [4:0] WORD_BITS     = 5'h10;
    localparam logic [4:0] HEADER_BITS   = 5'h08;
    localparam logic [7:0] SOFT_RESET_CYCLES = 8'h04;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_HOLD  = 3'b100
    } acp_state_e;

    typedef struct packed {
        logic       rw;
        logic [6:0] addr;
        logic [7:0] data;
    } acp_word_s;

    typedef struct packed {
        logic        overrange;
        logic [15:0] data;
    } acp_sample_s;

endpackage

//--- testbench/acp_mode_port_properties.sv
`timescale 1ns/100ps
module acp_mode_port_properties
(
    input wire logic                 clock,
    input wire logic                 reset,
    input wire logic                 program_mode_select,
    input wire logic                 cs_n,
    input wire logic                 sdi,
    input wire logic                 sck,
    input wire logic                 sdo_in,
    input wire logic                 sdo_out,
    input wire logic                 sdo_oe,
    input wire logic                 sample_valid,
    input wire acp_pkg::acp_sample_s sample_out,
    input wire logic                 sample_oe,
    input wire logic                 sample_clock_out,
    input wire logic                 sample_clock_oe,
    input wire logic [1:0]           power_down_code,
    input wire logic [1:0]           output_mode,
    input wire logic                 duty_cycle_stabilizer_en,
    input wire logic [1:0]           out_clock_phase_sel,
    input wire logic                 out_clock_invert
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // pins cross two sync flops plus a register, so five quiet samples are enough
    sdo_open_drain_a: assert property (sdo_oe |-> sdo_out == 1'b0)
        else $error("sdo drives high");
    sdo_released_a: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("sdo pulled outside a frame");
    oe_pair_a: assert property (sample_clock_oe == sample_oe)
        else $error("clock and data enables differ");
    clk_pulse_a: assert property (sample_valid ##1 $stable(out_clock_invert) |-> sample_clock_out != out_clock_invert)
        else $error("sample clock pulse missing");
    clk_idle_a: assert property (!sample_valid ##1 $stable(out_clock_invert) |-> sample_clock_out == out_clock_invert)
        else $error("sample clock idle level wrong");
    sample_hold_a: assert property (!sample_valid |=> $stable(sample_out))
        else $error("sample changed without a strobe");
    par_power_a: assert property ((program_mode_select && $stable({sdi, sdo_in, program_mode_select})) [*5]
        |-> power_down_code == {sdi, sdo_in}) else $error("strap power code wrong");
    par_mode_a: assert property ((program_mode_select && $stable({sck, cs_n, program_mode_select})) [*5]
        |-> output_mode == {1'b0, sck} && duty_cycle_stabilizer_en == cs_n && out_clock_phase_sel == 2'h0)
        else $error("strap mode wrong");
    serial_cmos_a: assert property ((!program_mode_select) [*5] |-> output_mode == acp_pkg::OUT_MODE_CMOS)
        else $error("serial mode output mode not cmos");
endmodule

bind acp_mode_port acp_mode_port_properties chk_u
(
    .clock(clock), .reset(reset), .program_mode_select(program_mode_select), .cs_n(cs_n), .sdi(sdi),
    .sck(sck), .sdo_in(sdo_in), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample_valid(sample_valid),
    .sample_out(sample_out), .sample_oe(sample_oe), .sample_clock_out(sample_clock_out),
    .sample_clock_oe(sample_clock_oe), .power_down_code(power_down_code), .output_mode(output_mode),
    .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en), .out_clock_phase_sel(out_clock_phase_sel),
    .out_clock_invert(out_clock_invert)
);

//--- testbench/acp_host_model.sv
`timescale 1ns/100ps
module acp_host_model
(
    input  wire logic clock,
    input  wire logic sdo_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      sdi,
    output logic      sdo
);
    logic strap_en = 1'b0;
    logic strap_o  = 1'b0;

    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end

    // external pull-up: the wire only reads data because of it
    assign sdo = sdo_oe ? 1'b0 : (strap_en ? strap_o : 1'b1);

    // sck half period of five clocks, stands low between frames
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        cs_n <= 1'b0;
        repeat (5) @(posedge clock);
        for (int i = 0; i < n; i++)
        begin
            sdi <= (i < 16) ? w[15 - i] : ~sdi;
            repeat (5) @(posedge clock);
            sck <= 1'b1;
            if (i >= 8 && i < 16)
                rd = {rd[6:0], sdo};
            repeat (5) @(posedge clock);
            sck <= 1'b0;
        end
        repeat (5) @(posedge clock);
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        repeat (5) @(posedge clock);
    endtask

    task automatic strap(input logic [3:0] v);
        cs_n     <= v[3];
        sck      <= v[2];
        sdi      <= v[1];
        strap_o  <= v[0];
        strap_en <= 1'b1;
    endtask

    task automatic release_pins();
        strap_en <= 1'b0;
        cs_n     <= 1'b1;
        sck      <= 1'b0;
    endtask
endmodule

//--- testbench/acp_mode_port_tb.sv
`timescale 1ns/100ps
module acp_mode_port_tb;
    logic                 clock = 1'b0;
    logic                 reset = 1'b1;
    logic                 program_mode_select = 1'b0;
    logic                 sample_valid = 1'b0;
    acp_pkg::acp_sample_s sample_in = '0;
    acp_pkg::acp_sample_s sample_out;
    logic                 cs_n, sck, sdi, sdo, sdo_out, sdo_oe, sample_oe, sample_clock_out, sample_clock_oe;
    logic [1:0]           power_down_code, output_mode, out_clock_phase_sel;
    logic                 duty_cycle_stabilizer_en, out_clock_invert;
    logic                 sv_d = 1'b0;
    logic                 saw_sleep = 1'b0;
    logic [7:0]           rd;
    int                   fail_count = 0;
    int                   n_tests = 0;
    acp_pkg::acp_sample_s exp_q[$];

    always #4 clock = ~clock;

    acp_mode_port dut_u
    (
        .clock(clock), .reset(reset), .program_mode_select(program_mode_select), .cs_n(cs_n), .sck(sck),
        .sdi(sdi), .sdo_in(sdo), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample_valid(sample_valid),
        .sample_in(sample_in), .sample_out(sample_out), .sample_oe(sample_oe),
        .sample_clock_out(sample_clock_out), .sample_clock_oe(sample_clock_oe),
        .power_down_code(power_down_code), .output_mode(output_mode),
        .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en), .out_clock_phase_sel(out_clock_phase_sel),
        .out_clock_invert(out_clock_invert)
    );

    acp_host_model host_u
    (
        .clock(clock), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo)
    );

    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
        logic [7:0] r;
        host_u.xfer({1'b0, a, d}, n, r);
        repeat (4) @(posedge clock);
    endtask

    // random sdi in the data half must not disturb a read
    task automatic rdr(input logic [6:0] a, output logic [7:0] r);
        host_u.xfer({1'b1, a, 8'($urandom)}, 16, r);
    endtask

    task automatic samples(input logic [2:0] code);
        logic [16:0] d;
        logic [16:0] e;
        for (int k = 0; k < 4; k++)
        begin
            d = 17'($urandom);
            case (code)
                acp_pkg::TEST_OFF:     e = d;
                acp_pkg::TEST_ZEROS:   e = 17'h00000;
                acp_pkg::TEST_ONES:    e = 17'h1FFFF;
                acp_pkg::TEST_CHECKER: e = k[0] ? 17'h0AAAA : 17'h15555;
                default:               e = k[0] ? 17'h1FFFF : 17'h00000;
            endcase
            exp_q.push_back(e);
            sample_in    <= d;
            sample_valid <= 1'b1;
            @(posedge clock);
            sample_valid <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask

    always @(posedge clock)
    begin
        sv_d <= sample_valid;
        if (power_down_code === acp_pkg::PD_SLEEP)
            saw_sleep <= 1'b1;
        if (sv_d)
        begin
            check("sample_out", sample_out, exp_q.pop_front());
            check("clock_out", 17'(sample_clock_out), 17'h1);
        end
    end

    initial
    begin
        repeat (60000) @(posedge clock);
        fail_count++;
        print_verdict();
    end

    initial
    begin
        logic [2:0] codes [5] = '{acp_pkg::TEST_OFF, acp_pkg::TEST_ZEROS, acp_pkg::TEST_ONES,
                                  acp_pkg::TEST_CHECKER, acp_pkg::TEST_TOGGLE};
        logic [3:0] t;
        void'($urandom(32'hFE717F88));
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        wr(acp_pkg::ADDR_SOFT_RESET_CTRL, 8'h80);
        repeat (8) @(posedge clock);
        check("sleep_pulse", 17'(saw_sleep), 17'h1);
        rdr(acp_pkg::ADDR_SOFT_RESET_CTRL, rd);
        check("reset_bit", 17'(rd), 17'h0);
        done("soft_reset");
        for (int c = 0; c < 4; c++)
        begin
            wr(acp_pkg::ADDR_POWER_DOWN_CTRL, {6'($urandom), 2'(c)});
            check("pd_code", 17'(power_down_code), 17'(c));
            rdr(acp_pkg::ADDR_POWER_DOWN_CTRL, rd);
            check("pd_read", 17'(rd[1:0]), 17'(c));
        end
        wr(acp_pkg::ADDR_POWER_DOWN_CTRL, 8'h00, 10);
        check("partial", 17'(power_down_code), 17'h3);
        wr(acp_pkg::ADDR_POWER_DOWN_CTRL, 8'h02, 17);
        check("extra_rise", 17'(power_down_code), 17'h2);
        done("power_down");
        for (int i = 0; i < 8; i++)
        begin
            t = {i[2:0], (i[1:0] != 2'h0) | 1'($urandom)};
            wr(acp_pkg::ADDR_OUTPUT_CLOCK_TIMING, {4'($urandom), t});
            check("clk_invert", 17'(out_clock_invert), 17'(t[3]));
            check("clk_phase", 17'(out_clock_phase_sel), 17'(t[2:1]));
            check("stabilizer", 17'(duty_cycle_stabilizer_en), 17'(t[0]));
            rdr(acp_pkg::ADDR_OUTPUT_CLOCK_TIMING, rd);
            check("timing_read", 17'(rd[3:0]), 17'(t));
        end
        wr(acp_pkg::ADDR_OUTPUT_CLOCK_TIMING, 8'h00);
        done("clock_timing");
        // both channels are still napping while the outputs float
        wr(acp_pkg::ADDR_OUTPUT_MODE, 8'h04);
        check("data_oe", 17'(sample_oe), 17'h0);
        check("clk_oe", 17'(sample_clock_oe), 17'h0);
        wr(acp_pkg::ADDR_OUTPUT_MODE, 8'h00);
        check("data_oe_on", 17'(sample_oe), 17'h1);
        done("output_disable");
        wr(acp_pkg::ADDR_POWER_DOWN_CTRL, 8'h00);
        repeat (100 + 6250) @(posedge clock);
        foreach (codes[j])
        begin
            wr(acp_pkg::ADDR_DATA_FORMAT, codes[j] == acp_pkg::TEST_OFF ? 8'h00 : {2'b11, codes[j], 3'b111});
            samples(codes[j]);
        end
        repeat (4) @(posedge clock);
        check("queue_empty", 17'(exp_q.size()), 17'h0);
        done("test_patterns");
        wr(acp_pkg::ADDR_POWER_DOWN_CTRL, 8'h01);
        // no sample is trusted after this sleep: its wake-up time outlasts the run
        wr(acp_pkg::ADDR_SOFT_RESET_CTRL, 8'h80);
        repeat (8) @(posedge clock);
        check("pd_cleared", 17'(power_down_code), 17'h0);
        rdr(acp_pkg::ADDR_DATA_FORMAT, rd);
        check("format_cleared", 17'(rd), 17'h0);
        rdr(7'h55, rd);
        check("unmapped", 17'(rd), 17'h0);
        done("register_clear");
        program_mode_select <= 1'b1;
        for (int v = 0; v < 16; v++)
        begin
            host_u.strap(4'(v));
            repeat (8) @(posedge clock);
            check("par_stabilizer", 17'(duty_cycle_stabilizer_en), 17'(v[3]));
            check("par_out_mode", 17'(output_mode), 17'(v[2]));
            check("par_power", 17'(power_down_code), 17'(v[1:0]));
            check("par_clock", 17'({out_clock_invert, out_clock_phase_sel}), 17'h0);
        end
        program_mode_select <= 1'b0;
        host_u.release_pins();
        repeat (8) @(posedge clock);
        done("parallel");
        print_verdict();
    end
endmodule
